// *** pwm16_pkg.sv ***
// Package for the sixteen-channel PWM output stage.
// Assumes a 125 MHz core clock and a plain register port.
package pwm16_pkg;
  // Core clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 8000;
  // Channel count and data widths.
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets on the register port.
  localparam logic [3:0] OFS_OE_LOW = 4'h0;
  localparam logic [3:0] OFS_OE_HIGH = 4'h1;
  localparam logic [3:0] OFS_CLK_SEL = 4'h2;
  localparam logic [3:0] OFS_P1_DIR = 4'h3;
  localparam logic [3:0] OFS_P2_DIR = 4'h4;
  localparam logic [3:0] OFS_P1_LVL = 4'h5;
  localparam logic [3:0] OFS_P2_LVL = 4'h6;
  localparam logic [3:0] OFS_MSTOP_HIGH = 4'h7;
  localparam logic [3:0] OFS_MSTOP_LOW = 4'h8;
  localparam logic [3:0] OFS_REG_SEL = 4'h9;
  localparam logic [3:0] OFS_DUTY = 4'hA;
  localparam logic [3:0] OFS_POL_LOW = 4'hB;
  localparam logic [3:0] OFS_POL_HIGH = 4'hC;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_MSTOP = 16'h3FFF;
  localparam logic [7:0] RST_REG_SEL = 8'h20;
  // Writable mask of the peripheral clock select register.
  localparam logic [7:0] CLK_SEL_MASK = 8'h06;
  // Field positions.
  localparam int CLK_DIV_A_BIT = 1;
  localparam int CLK_DIV_B_BIT = 2;
  localparam int MSTOP_BIT = 3;
  localparam int CKE_BIT = 7;
  localparam int CKS_BIT = 6;
  localparam int RSEL_FIXED_BIT = 5;
  localparam int RSEL_LSB = 0;
  localparam int RSEL_W = 4;
  localparam int NIB_W = 4;
  // Last position inside a basic pulse.
  localparam logic [3:0] POS_LAST = 4'hF;
  // Prescaler masks for divide by 2, 4, 8 and 16.
  localparam logic [3:0] DIV2_MASK = 4'h1;
  localparam logic [3:0] DIV4_MASK = 4'h3;
  localparam logic [3:0] DIV8_MASK = 4'h7;
  localparam logic [3:0] DIV16_MASK = 4'hF;
  // Counter clock choices.
  typedef enum logic [2:0] {
    PWM_CLK_OFF, PWM_CLK_DIV1, PWM_CLK_DIV2,
    PWM_CLK_DIV4, PWM_CLK_DIV8, PWM_CLK_DIV16
  } pwm_clk_e;
endpackage

// *** pwm16_output_stage.sv ***
// Sixteen-channel 8-bit PWM output stage with its register file.
// Assumes synchronous inputs and a master that follows the strobe port rules.
//
// Contract
// - Each output-enable bit picks modulator or port output for its channel.
// - A pin is driven only while its direction bit is one.
// - Direction and enable give PWM; direction alone gives the static level.
// - First port directions map channels 7..0, second port channels 15..8.
// - Both output-enable registers clear to zero at reset.
// - Divider bits 2 and 1 join enable and select bits to pick clock.
// - Clock select resets to zero; bits 7 to 3 and bit 0 read zero, ignore writes.
// - Direction registers are write-only, eight bits, and reset to zero.
// - Port level bit sets the pin level in port-output mode.
// - Stop bit 3 of the high stop byte halts the modulator; resets one.
// - Stop register pair resets to 0x3FFF.
// - Upper duty nibble sets basic pulse duty 0/16 to 15/16.
// - Lower nibble N adds extra pulses to first N slots of fixed order.
// - Extra pulse is one resolution wide, just before the basic rising edge.
// - With upper nibble zero, extra pulses keep the same slot timing.
// - Polarity one inverts the output so duty defines the low time.
// - Clock enable zero stops counting; otherwise divide by 1,2,4,8,16.
// - Conversion period is 256 counter clocks with 16 basic pulses.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwm16_output_stage
  import pwm16_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Channel pins.
  output logic [NUM_CH-1:0] pin_out_o,
  output logic [NUM_CH-1:0] pin_oe_o,
  // Status.
  output logic [7:0] timing_counter_o,
  output logic modulator_stopped_o
);

  // Software-visible registers.
  logic [7:0] oe_low_r;
  logic [7:0] oe_low_nxt;
  logic [7:0] oe_high_r;
  logic [7:0] oe_high_nxt;
  logic [7:0] clk_sel_r;
  logic [7:0] clk_sel_nxt;
  logic [7:0] p1_dir_r;
  logic [7:0] p1_dir_nxt;
  logic [7:0] p2_dir_r;
  logic [7:0] p2_dir_nxt;
  logic [7:0] p1_lvl_r;
  logic [7:0] p1_lvl_nxt;
  logic [7:0] p2_lvl_r;
  logic [7:0] p2_lvl_nxt;
  logic [15:0] mstop_r;
  logic [15:0] mstop_nxt;
  logic [7:0] reg_sel_r;
  logic [7:0] reg_sel_nxt;
  logic [7:0] pol_low_r;
  logic [7:0] pol_low_nxt;
  logic [7:0] pol_high_r;
  logic [7:0] pol_high_nxt;
  logic [7:0] duty_r [NUM_CH];
  logic [7:0] duty_nxt [NUM_CH];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Timing state.
  logic [3:0] presc_r;
  logic [3:0] presc_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [NUM_CH-1:0] pin_r;
  logic [NUM_CH-1:0] pin_nxt;
  logic [NUM_CH-1:0] oe_r;
  logic [NUM_CH-1:0] oe_nxt;

  // Derived signals.
  logic stop;
  logic tick;
  pwm_clk_e clk_mode;
  logic [RSEL_W-1:0] rsel;
  logic [NUM_CH-1:0] dir_all;
  logic [NUM_CH-1:0] oe_all;
  logic [NUM_CH-1:0] lvl_all;
  logic [NUM_CH-1:0] pol_all;
  logic [NUM_CH-1:0] wave;
  logic [3:0] slot;
  logic [3:0] pos;

  assign stop = mstop_r[8+MSTOP_BIT];
  assign rsel = reg_sel_r[RSEL_LSB +: RSEL_W];
  assign dir_all = {p2_dir_r, p1_dir_r};
  assign oe_all = {oe_high_r, oe_low_r};
  assign lvl_all = {p2_lvl_r, p1_lvl_r};
  assign pol_all = {pol_high_r, pol_low_r};
  assign slot = cnt_r[7:4];
  assign pos = cnt_r[3:0];

  // Counter clock choice from the select and divider bits.
  always_comb begin
    if (!reg_sel_r[CKE_BIT]) begin
      clk_mode = PWM_CLK_OFF;
    end else if (!reg_sel_r[CKS_BIT]) begin
      clk_mode = PWM_CLK_DIV1;
    end else begin
      unique case ({clk_sel_r[CLK_DIV_B_BIT], clk_sel_r[CLK_DIV_A_BIT]})
        2'b00: clk_mode = PWM_CLK_DIV2;
        2'b01: clk_mode = PWM_CLK_DIV4;
        2'b10: clk_mode = PWM_CLK_DIV8;
        2'b11: clk_mode = PWM_CLK_DIV16;
      endcase
    end
  end

  // One-cycle enable pulse at the selected counter rate.
  always_comb begin
    unique case (clk_mode)
      PWM_CLK_OFF: tick = 1'b0;
      PWM_CLK_DIV1: tick = 1'b1;
      PWM_CLK_DIV2: tick = ((presc_r & DIV2_MASK) == DIV2_MASK);
      PWM_CLK_DIV4: tick = ((presc_r & DIV4_MASK) == DIV4_MASK);
      PWM_CLK_DIV8: tick = ((presc_r & DIV8_MASK) == DIV8_MASK);
      PWM_CLK_DIV16: tick = ((presc_r & DIV16_MASK) == DIV16_MASK);
      default: tick = 1'b0;
    endcase
  end

  // Prescaler and timing counter.
  always_comb begin
    presc_nxt = presc_r + 4'h1;
    cnt_nxt = cnt_r;
    if (stop) begin
      presc_nxt = 4'h0;
      cnt_nxt = 8'h00;
    end else if (tick) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_r <= 4'h0;
      cnt_r <= 8'h00;
    end else begin
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Per-channel waveform.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [3:0] hi_nib;
      logic [3:0] lo_nib;
      logic [3:0] rank;
      logic basic;
      logic extra;
      assign hi_nib = duty_r[ch][7:4];
      assign lo_nib = duty_r[ch][3:0];
      // Slot order 15,7,11,3,... is the bit reverse of the inverted slot.
      assign rank = {~slot[0], ~slot[1], ~slot[2], ~slot[3]};
      // Basic pulse sits at the end of its slot, hi_nib positions long.
      assign basic = ({1'b0, pos} >= (5'h10 - {1'b0, hi_nib}));
      // Extra pulse fills the position just before the rising edge.
      assign extra = (rank < lo_nib) && (pos == (POS_LAST - hi_nib));
      assign wave[ch] = (basic | extra) ^ pol_all[ch];
    end
  endgenerate

  // Pin drive: PWM when enabled, port level otherwise, only with direction.
  always_comb begin
    oe_nxt = dir_all;
    for (int i = 0; i < NUM_CH; i++) begin
      pin_nxt[i] = 1'b0;
      if (dir_all[i]) begin
        pin_nxt[i] = oe_all[i] ? wave[i] : lvl_all[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_r <= '0;
      oe_r <= '0;
    end else begin
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Register writes.
  always_comb begin
    oe_low_nxt = oe_low_r;
    oe_high_nxt = oe_high_r;
    clk_sel_nxt = clk_sel_r;
    p1_dir_nxt = p1_dir_r;
    p2_dir_nxt = p2_dir_r;
    p1_lvl_nxt = p1_lvl_r;
    p2_lvl_nxt = p2_lvl_r;
    mstop_nxt = mstop_r;
    reg_sel_nxt = reg_sel_r;
    pol_low_nxt = pol_low_r;
    pol_high_nxt = pol_high_r;
    for (int i = 0; i < NUM_CH; i++) begin
      duty_nxt[i] = duty_r[i];
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_OE_LOW: oe_low_nxt = reg_wdata_i;
        OFS_OE_HIGH: oe_high_nxt = reg_wdata_i;
        OFS_CLK_SEL: clk_sel_nxt = reg_wdata_i & CLK_SEL_MASK;
        OFS_P1_DIR: p1_dir_nxt = reg_wdata_i;
        OFS_P2_DIR: p2_dir_nxt = reg_wdata_i;
        OFS_P1_LVL: p1_lvl_nxt = reg_wdata_i;
        OFS_P2_LVL: p2_lvl_nxt = reg_wdata_i;
        OFS_MSTOP_HIGH: mstop_nxt[15:8] = reg_wdata_i;
        OFS_MSTOP_LOW: mstop_nxt[7:0] = reg_wdata_i;
        OFS_REG_SEL: begin
          reg_sel_nxt = reg_wdata_i;
          reg_sel_nxt[RSEL_FIXED_BIT] = 1'b1;
          reg_sel_nxt[RSEL_FIXED_BIT-1] = 1'b0;
        end
        OFS_DUTY: duty_nxt[rsel] = reg_wdata_i;
        OFS_POL_LOW: pol_low_nxt = reg_wdata_i;
        OFS_POL_HIGH: pol_high_nxt = reg_wdata_i;
        default: begin
        end
      endcase
    end
    // Module stop holds select and duty registers at their initial values.
    if (stop) begin
      reg_sel_nxt = RST_REG_SEL;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_nxt[i] = RST_BYTE;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_low_r <= RST_BYTE;
      oe_high_r <= RST_BYTE;
      clk_sel_r <= RST_BYTE;
      p1_dir_r <= RST_BYTE;
      p2_dir_r <= RST_BYTE;
      p1_lvl_r <= RST_BYTE;
      p2_lvl_r <= RST_BYTE;
      mstop_r <= RST_MSTOP;
      reg_sel_r <= RST_REG_SEL;
      pol_low_r <= RST_BYTE;
      pol_high_r <= RST_BYTE;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_r[i] <= RST_BYTE;
      end
    end else begin
      oe_low_r <= oe_low_nxt;
      oe_high_r <= oe_high_nxt;
      clk_sel_r <= clk_sel_nxt;
      p1_dir_r <= p1_dir_nxt;
      p2_dir_r <= p2_dir_nxt;
      p1_lvl_r <= p1_lvl_nxt;
      p2_lvl_r <= p2_lvl_nxt;
      mstop_r <= mstop_nxt;
      reg_sel_r <= reg_sel_nxt;
      pol_low_r <= pol_low_nxt;
      pol_high_r <= pol_high_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        duty_r[i] <= duty_nxt[i];
      end
    end
  end

  // Register reads; direction registers and unmapped offsets read zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_OE_LOW: rdata_nxt = oe_low_r;
        OFS_OE_HIGH: rdata_nxt = oe_high_r;
        OFS_CLK_SEL: rdata_nxt = clk_sel_r;
        OFS_P1_LVL: rdata_nxt = p1_lvl_r;
        OFS_P2_LVL: rdata_nxt = p2_lvl_r;
        OFS_MSTOP_HIGH: rdata_nxt = mstop_r[15:8];
        OFS_MSTOP_LOW: rdata_nxt = mstop_r[7:0];
        OFS_REG_SEL: rdata_nxt = reg_sel_r;
        OFS_DUTY: rdata_nxt = duty_r[rsel];
        OFS_POL_LOW: rdata_nxt = pol_low_r;
        OFS_POL_HIGH: rdata_nxt = pol_high_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign pin_out_o = pin_r;
  assign pin_oe_o = oe_r;
  assign timing_counter_o = cnt_r;
  assign modulator_stopped_o = stop;

endmodule
`default_nettype wire

// *** pwm16_chk_assertions.sv ***
// Port checker for the PWM output stage.
// Bound to every instance of the output stage.
`timescale 1ns/1ps
`default_nettype none
module pwm16_chk
  import pwm16_pkg::*;
(
  // Watched ports.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_CH-1:0] pin_out_o,
  input wire logic [NUM_CH-1:0] pin_oe_o,
  input wire logic [7:0] timing_counter_o,
  input wire logic modulator_stopped_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  dir_low_map_a: assert property (
    reg_wr_i && reg_addr_i == OFS_P1_DIR |-> ##2 pin_oe_o[7:0] == $past(reg_wdata_i, 2))
    else $error("low enables wrong");
  dir_high_map_a: assert property (
    reg_wr_i && reg_addr_i == OFS_P2_DIR |-> ##2 pin_oe_o[15:8] == $past(reg_wdata_i, 2))
    else $error("high enables wrong");
  undriven_low_a: assert property ((pin_out_o & ~pin_oe_o) == 16'h0000)
    else $error("undriven pin high");
  stop_write_a: assert property (
    reg_wr_i && reg_addr_i == OFS_MSTOP_HIGH |=>
    modulator_stopped_o == $past(reg_wdata_i[MSTOP_BIT])) else $error("stop bit wrong");
  stop_holds_a: assert property (modulator_stopped_o |=> timing_counter_o == 8'h00)
    else $error("counter runs in stop");
  read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data without read");
  clk_sel_rsvd_a: assert property (
    reg_rd_i && reg_addr_i == OFS_CLK_SEL |=> (reg_rdata_o & ~CLK_SEL_MASK) == 8'h00)
    else $error("reserved bits set");
  cnt_step_a: assert property (
    timing_counter_o != $past(timing_counter_o) |->
    timing_counter_o == $past(timing_counter_o) + 8'h01 || timing_counter_o == 8'h00)
    else $error("counter jumped");
endmodule
bind pwm16_output_stage pwm16_chk chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .timing_counter_o(timing_counter_o),
  .modulator_stopped_o(modulator_stopped_o));
`default_nettype wire

// *** pwm16_load.sv ***
// Model of the loads on the sixteen channel pins.
// Assumes a pin floats while the stage does not drive it.
`timescale 1ns/1ps
`default_nettype none
module pwm16_load (
  // Pin side.
  input wire logic clk_i,
  input wire logic [15:0] pin_out_i,
  input wire logic [15:0] pin_oe_i,
  // Pad levels.
  output logic [15:0] pad_o
);
  logic [15:0] float_r = 16'h5AA5;
  // A floating pad changes every cycle.
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  assign pad_o = (pin_out_i & pin_oe_i) | (float_r & ~pin_oe_i);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the PWM output stage.
// Drives the register port; checks pads through the load model.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pwm16_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata, cnt, c;
  logic [15:0] pin_out, pin_oe, pad, pol, oe, dir, lvl;
  logic stopped;
  logic [7:0] duty [16];
  logic [3:0] order [15] = '{4'hF, 4'h7, 4'hB, 4'h3, 4'hD, 4'h5, 4'h9, 4'h1,
    4'hE, 4'h6, 4'hA, 4'h2, 4'hC, 4'h4, 4'h8};
  logic [7:0] rs [6] = '{8'h00, 8'h80, 8'hC0, 8'hC0, 8'hC0, 8'hC0};
  logic [7:0] pc [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h06};
  logic [7:0] dl [6] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'hccd6;
  always #4 clk = ~clk;
  pwm16_output_stage dut (.core_clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .timing_counter_o(cnt),
    .modulator_stopped_o(stopped));
  pwm16_load load (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pad_o(pad));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    cmp(rdata, e);
  endtask
  function automatic logic wave(input logic [7:0] d, input logic [7:0] t);
    logic x;
    x = 1'b0;
    for (int k = 0; k < 15; k++)
      if (k < d[3:0] && order[k] == t[7:4]) x = 1'b1;
    return ({1'b0, t[3:0]} >= 5'h10 - d[7:4]) || (x && t[3:0] == 4'hF - d[7:4]);
  endfunction
  function automatic logic [15:0] exp_pins(input logic [7:0] t);
    logic [15:0] p;
    for (int i = 0; i < 16; i++)
      p[i] = oe[i] ? wave(duty[i], t) ^ pol[i] : lvl[i];
    return p & dir;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 1300 cycles.
  initial begin
    #160000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 16; a++)
      rd(a[3:0], a == 7 ? 8'h3F : a == 8 ? 8'hFF : a == 9 ? 8'h20 : 8'h00);
    cmp(stopped, 1'b1);
    wr(OFS_CLK_SEL, 8'hFE);
    rd(OFS_CLK_SEL, 8'h06);
    wr(OFS_MSTOP_HIGH, 8'h37);
    @(negedge clk);
    cmp(stopped, 1'b0);
    $display("test registers done");
    repeat (2) begin
      dir = 16'($random(seed)) | 16'h00FF;
      oe = 16'($random(seed)) | 16'h001F;
      pol = 16'($random(seed)) & 16'hFFF0;
      lvl = 16'($random(seed));
      for (int i = 0; i < 16; i++) duty[i] = 8'($random(seed));
      duty[0] = 8'h0F;
      duty[1] = 8'hF0;
      duty[2] = 8'h00;
      duty[3] = 8'hFF;
      duty[4] = 8'h88;
      wr(OFS_OE_LOW, oe[7:0]);
      wr(OFS_OE_HIGH, oe[15:8]);
      wr(OFS_P1_DIR, dir[7:0]);
      wr(OFS_P2_DIR, dir[15:8]);
      wr(OFS_P1_LVL, lvl[7:0]);
      wr(OFS_P2_LVL, lvl[15:8]);
      wr(OFS_POL_LOW, pol[7:0]);
      wr(OFS_POL_HIGH, pol[15:8]);
      rd(OFS_OE_HIGH, oe[15:8]);
      rd(OFS_POL_HIGH, pol[15:8]);
      rd(OFS_P1_LVL, lvl[7:0]);
      for (int i = 0; i < 16; i++) begin
        wr(OFS_REG_SEL, 8'h80 | 8'(i));
        wr(OFS_DUTY, duty[i]);
        rd(OFS_DUTY, duty[i]);
      end
      cmp(pin_oe, dir);
      for (int k = 0; k < 300; k++) begin
        c = cnt;
        @(negedge clk);
        cmp(pad & dir, exp_pins(c));
      end
    end
    $display("test waveform done");
    for (int m = 0; m < 6; m++) begin
      wr(OFS_CLK_SEL, pc[m]);
      wr(OFS_REG_SEL, rs[m]);
      @(negedge clk);
      c = cnt;
      repeat (64) @(negedge clk);
      cmp(8'(cnt - c), dl[m]);
    end
    $display("test clock done");
    wr(OFS_MSTOP_HIGH, 8'h3F);
    repeat (2) @(negedge clk);
    cmp({stopped, cnt}, 9'h100);
    rd(OFS_DUTY, 8'h00);
    rd(OFS_OE_HIGH, oe[15:8]);
    wr(OFS_MSTOP_LOW, 8'h5A);
    rd(OFS_MSTOP_LOW, 8'h5A);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_OE_HIGH, 8'h00);
    rd(OFS_MSTOP_LOW, 8'hFF);
    rd(OFS_CLK_SEL, 8'h00);
    cmp(stopped, 1'b1);
    cmp(pin_oe, 16'h0000);
    $display("test stop done");
    close_out();
  end
endmodule
`default_nettype wire
